// ---- rtl/ebrc_defines.vh ----
// Purpose: shared constants of the embedded block RAM core
// Assumes: one clock; all control inputs come from logic on that clock
// Notes:   width codes select one of nine port shapes; lanes are 9 bits
// Summary of operation
// - Storage is 8192 data bits, 9216 counting the ninth bit of each byte.
// - Shapes: 8192x1, 4096x2, 2048x4, 1024x8/9, 512x16/18, 256x32/36.
// - Single-port accepts every port width; simple dual-port needs both ports at 9, 18 or 36 bits, or neither.
// - True dual-port allows read plus write, two reads or two writes.
// - Differing widths in true dual-port exclude the 32 and 36 bit shapes.
// - Reads and writes happen only on rising clock edges.
// - Port clear reaches only read address, output register and latch.
// - Cross-port read of a written address gives old or undefined data.
// - Clock enable low freezes a port's registers and its memory access.
// - Each port has separate read and write enables, droppable anytime.
// - Ninth bit is plain data; no parity is generated or checked.
// - Writes of 16 to 36 bits update only lanes whose mask bit is high.
// - Mask defaults to all ones and its path has no clear.
// - Lane masking applies only to 16, 18, 32 and 36 bit writes.
// - Mask bit n picks lane n from the LSB; 8 or 9 bit lanes.
// - During write, masked lanes read old; enabled lanes new or old.
// - Packed mode: two single-port halves, at most 18 bits, one clock.
// - Address hold high recirculates the port's address register.
// - Address hold defaults low so every enabled edge loads an address.
// - Output register adds exactly one cycle of read latency.
// - Write with read enable low keeps the last read data on outputs.
`ifndef EBRC_DEFINES_VH
`define EBRC_DEFINES_VH

// Port width codes
`define EBRC_W1         4'h0
`define EBRC_W2         4'h1
`define EBRC_W4         4'h2
`define EBRC_W8         4'h3
`define EBRC_W9         4'h4
`define EBRC_W16        4'h5
`define EBRC_W18        4'h6
`define EBRC_W32        4'h7
`define EBRC_W36        4'h8

// Memory modes
`define EBRC_MODE_SP    2'h0
`define EBRC_MODE_SDP   2'h1
`define EBRC_MODE_TDP   2'h2
`define EBRC_MODE_PACK  2'h3

// Storage shape and reset values
`define EBRC_LANES      1024
`define EBRC_ADDR_RST   13'h0000
`define EBRC_DATA_RST   36'h0_0000_0000
`define EBRC_ERR_RST    1'h0
`define EBRC_DONT_CARE  36'hF_FFFF_FFFF
`define EBRC_MASK_ALL   4'hF

`endif

// ---- rtl/ebrc_top.v ----
// Purpose: embedded block RAM with two ports, lane masks and packed mode
// Assumes: both ports run on sys_clk_i; inputs are synchronous to it
// Notes:   storage is 1024 lanes of 9 bits; 8-bit shapes leave bit 8 unused
`include "ebrc_defines.vh"

module ebrc_top (
    // Clock and device reset
    input  wire        sys_clk_i,
    input  wire        arst_n_i,
    // Block configuration
    input  wire [1:0]  mode_i,
    input  wire        mix_old_i,
    // Port A configuration
    input  wire [3:0]  a_width_i,
    input  wire        a_out_reg_i,
    input  wire        a_rdw_new_i,
    // Port A controls and data
    input  wire        a_clk_en_i,
    input  wire        a_wr_en_i,
    input  wire        a_rd_en_i,
    input  wire        a_addr_hold_i,
    input  wire        a_clr_i,
    input  wire [3:0]  a_lane_mask_i,
    input  wire [12:0] a_addr_i,
    input  wire [35:0] a_wdata_i,
    output wire [35:0] a_rdata_o,
    // Port B configuration
    input  wire [3:0]  b_width_i,
    input  wire        b_out_reg_i,
    input  wire        b_rdw_new_i,
    // Port B controls and data
    input  wire        b_clk_en_i,
    input  wire        b_wr_en_i,
    input  wire        b_rd_en_i,
    input  wire        b_addr_hold_i,
    input  wire        b_clr_i,
    input  wire [3:0]  b_lane_mask_i,
    input  wire [12:0] b_addr_i,
    input  wire [35:0] b_wdata_i,
    output wire [35:0] b_rdata_o,
    // Status
    output wire        cfg_err_o
);

    // First lane touched by an access of the given width
    function [9:0] fn_base;
        input [3:0]  wc;
        input [12:0] a;
        begin
            case (wc)
                `EBRC_W1:            fn_base = a[12:3];
                `EBRC_W2:            fn_base = a[11:2];
                `EBRC_W4:            fn_base = a[10:1];
                `EBRC_W16, `EBRC_W18: fn_base = {a[8:0], 1'b0};
                `EBRC_W32, `EBRC_W36: fn_base = {a[7:0], 2'b00};
                default:             fn_base = a[9:0];
            endcase
        end
    endfunction

    // Bit offset inside a lane for sub-byte shapes
    function [2:0] fn_off;
        input [3:0]  wc;
        input [12:0] a;
        begin
            case (wc)
                `EBRC_W1: fn_off = a[2:0];
                `EBRC_W2: fn_off = {a[1:0], 1'b0};
                `EBRC_W4: fn_off = {a[0], 2'b00};
                default:  fn_off = 3'h0;
            endcase
        end
    endfunction

    // Sub-byte width, zero for whole-lane shapes
    function [2:0] fn_sw;
        input [3:0] wc;
        begin
            case (wc)
                `EBRC_W1: fn_sw = 3'h1;
                `EBRC_W2: fn_sw = 3'h2;
                `EBRC_W4: fn_sw = 3'h4;
                default:  fn_sw = 3'h0;
            endcase
        end
    endfunction

    // Number of lanes minus one
    function [1:0] fn_nlm1;
        input [3:0] wc;
        begin
            case (wc)
                `EBRC_W16, `EBRC_W18: fn_nlm1 = 2'h1;
                `EBRC_W32, `EBRC_W36: fn_nlm1 = 2'h3;
                default:             fn_nlm1 = 2'h0;
            endcase
        end
    endfunction

    // Shapes that use all nine bits of a lane
    function fn_par;
        input [3:0] wc;
        begin
            fn_par = (wc == `EBRC_W9) || (wc == `EBRC_W18) || (wc == `EBRC_W36);
        end
    endfunction

    // Storage, one 9-bit word per lane
    reg  [8:0]  mem [0:`EBRC_LANES-1];

    // Mode decode results and the error flag register
    reg         cfg_ok;
    reg  [1:0]  wr_ok;
    reg  [1:0]  rd_ok;
    reg         err_q;
    // Loop indices of the array update
    integer     m_p;
    integer     m_k;
    integer     m_j;

    // Per-port inputs gathered by index
    wire [7:0]  width_w = {b_width_i, a_width_i};
    wire [1:0]  ce_w    = {b_clk_en_i, a_clk_en_i};
    wire [1:0]  wren_w  = {b_wr_en_i, a_wr_en_i};
    wire [1:0]  rden_w  = {b_rd_en_i, a_rd_en_i};
    wire [1:0]  hold_w  = {b_addr_hold_i, a_addr_hold_i};
    wire [1:0]  clr_w   = {b_clr_i, a_clr_i};
    wire [1:0]  oreg_w  = {b_out_reg_i, a_out_reg_i};
    wire [1:0]  rdwn_w  = {b_rdw_new_i, a_rdw_new_i};
    wire [7:0]  mask_w  = {b_lane_mask_i, a_lane_mask_i};
    wire [25:0] addr_w  = {b_addr_i, a_addr_i};
    wire [71:0] wdata_w = {b_wdata_i, a_wdata_i};
    wire        pack_w  = (mode_i == `EBRC_MODE_PACK);

    // Per-port results gathered by index
    wire [71:0] we_all;
    wire [71:0] wd_all;
    wire [19:0] wbase_all;
    wire [3:0]  wnl_all;
    wire [1:0]  wact_all;
    wire [71:0] q_all;

    // Legal shape check and which port may read or write in each mode
    always @* begin
        cfg_ok = 1'b0;
        wr_ok  = 2'b00;
        rd_ok  = 2'b00;
        case (mode_i)
            `EBRC_MODE_SP: begin
                cfg_ok = (a_width_i <= `EBRC_W36);
                wr_ok  = 2'b01;
                rd_ok  = 2'b01;
            end
            `EBRC_MODE_SDP: begin
                cfg_ok = (a_width_i <= `EBRC_W36) && (b_width_i <= `EBRC_W36) &&
                         (fn_par(a_width_i) == fn_par(b_width_i));
                wr_ok  = 2'b01;
                rd_ok  = 2'b10;
            end
            `EBRC_MODE_TDP: begin
                cfg_ok = (a_width_i <= `EBRC_W36) && (b_width_i <= `EBRC_W36) &&
                         (fn_par(a_width_i) == fn_par(b_width_i)) &&
                         ((a_width_i == b_width_i) ||
                          ((a_width_i < `EBRC_W32) && (b_width_i < `EBRC_W32)));
                wr_ok  = 2'b11;
                rd_ok  = 2'b11;
            end
            `EBRC_MODE_PACK: begin
                cfg_ok = (a_width_i <= `EBRC_W18) && (b_width_i <= `EBRC_W18);
                wr_ok  = 2'b11;
                rd_ok  = 2'b11;
            end
            default: begin
                cfg_ok = 1'b0;
            end
        endcase
        if (!cfg_ok) begin
            wr_ok = 2'b00;
            rd_ok = 2'b00;
        end
    end

    // Port logic, one copy per port
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp = gp + 1) begin : g_port
            // Half of the array that this port owns in packed mode
            localparam [0:0] HALF = (gp == 1) ? 1'b1 : 1'b0;
            // Held addresses, output latch and output register
            reg  [12:0] raddr_q;
            reg  [12:0] waddr_q;
            reg  [35:0] lat_q;
            reg  [35:0] q_q;
            // Scratch of the write strobe and read merge processes
            reg  [35:0] wbit;
            reg  [35:0] wval;
            reg  [35:0] old_v;
            reg  [35:0] mrg_v;
            reg  [35:0] rd_v;
            reg  [3:0]  bmask;
            reg  [10:0] lo_r;
            reg  [10:0] hi_r;
            reg  [10:0] lo_w;
            reg  [10:0] hi_w;
            reg         coll;
            // Loop indices
            integer     i;
            integer     j;
            integer     k;
            // This port's slice of the gathered inputs and its decoded access
            wire        clr   = clr_w[gp];
            wire [3:0]  wc    = width_w[4*gp +: 4];
            wire [12:0] ra    = hold_w[gp] ? raddr_q : addr_w[13*gp +: 13];
            wire [12:0] wa    = hold_w[gp] ? waddr_q : addr_w[13*gp +: 13];
            wire [9:0]  rb0   = fn_base(wc, ra);
            wire [9:0]  wb0   = fn_base(wc, wa);
            wire [9:0]  rb    = pack_w ? {HALF, rb0[8:0]} : rb0;
            wire [9:0]  wb    = pack_w ? {HALF, wb0[8:0]} : wb0;
            wire [2:0]  sw    = fn_sw(wc);
            wire [1:0]  nlm1  = fn_nlm1(wc);
            wire        par   = fn_par(wc);
            wire [2:0]  roff  = fn_off(wc, ra);
            wire [2:0]  woff  = fn_off(wc, wa);
            wire        wact  = ce_w[gp] & wren_w[gp] & wr_ok[gp];
            wire        ract  = ce_w[gp] & rden_w[gp] & rd_ok[gp];
            wire [35:0] din   = wdata_w[36*gp +: 36];
            wire [35:0] lat_d = ract ? rd_v : lat_q;

            // Lane and bit write strobes; narrow shapes ignore the mask
            always @* begin
                wbit  = 36'h0_0000_0000;
                wval  = 36'h0_0000_0000;
                bmask = (nlm1 == 2'h0) ? `EBRC_MASK_ALL : mask_w[4*gp +: 4];
                for (i = 0; i < 4; i = i + 1) begin
                    if (wact && (sw != 3'h0) && (i < sw)) begin
                        wbit[woff + i] = 1'b1;
                        wval[woff + i] = din[i];
                    end else if (wact && (sw == 3'h0) && (i <= nlm1) && bmask[i]) begin
                        if (par) begin
                            wbit[9*i +: 9] = 9'h1FF;
                            wval[9*i +: 9] = din[9*i +: 9];
                        end else begin
                            wbit[9*i +: 8] = 8'hFF;
                            wval[9*i +: 8] = din[8*i +: 8];
                        end
                    end
                end
            end

            // Read path with same-port and cross-port collision handling
            always @* begin
                old_v = 36'h0_0000_0000;
                rd_v  = 36'h0_0000_0000;
                for (k = 0; k < 4; k = k + 1) begin
                    old_v[9*k +: 9] = mem[{rb[9:2], rb[1:0] | k[1:0]}];
                end
                lo_r = {1'b0, rb};
                hi_r = lo_r + {9'h000, nlm1};
                lo_w = {1'b0, wbase_all[10*(1-gp) +: 10]};
                hi_w = lo_w + {9'h000, wnl_all[2*(1-gp) +: 2]};
                coll = wact_all[1-gp] && !((hi_r < lo_w) || (hi_w < lo_r));
                mrg_v = old_v;
                if ((ra == wa) && rdwn_w[gp]) begin
                    mrg_v = (wbit & wval) | (~wbit & old_v);
                end
                if (coll && !mix_old_i) begin
                    mrg_v = `EBRC_DONT_CARE;
                end
                for (j = 0; j < 4; j = j + 1) begin
                    if ((sw != 3'h0) && (j < sw)) begin
                        rd_v[j] = mrg_v[roff + j];
                    end else if ((sw == 3'h0) && (j <= nlm1)) begin
                        if (par) begin
                            rd_v[9*j +: 9] = mrg_v[9*j +: 9];
                        end else begin
                            rd_v[8*j +: 8] = mrg_v[9*j +: 8];
                        end
                    end
                end
            end

            // Read address, output latch and output register; port clear applies
            always @(posedge sys_clk_i or negedge arst_n_i or posedge clr) begin
                if (!arst_n_i || clr) begin
                    raddr_q <= `EBRC_ADDR_RST;
                    lat_q   <= `EBRC_DATA_RST;
                    q_q     <= `EBRC_DATA_RST;
                end else if (ce_w[gp]) begin
                    raddr_q <= ra;
                    lat_q   <= lat_d;
                    q_q     <= oreg_w[gp] ? lat_q : lat_d;
                end
            end

            // Write address register: device reset only, no port clear
            always @(posedge sys_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    waddr_q <= `EBRC_ADDR_RST;
                end else if (ce_w[gp]) begin
                    waddr_q <= wa;
                end
            end

            // Hand this port's strobes and read data back to the shared logic
            assign we_all[36*gp +: 36]   = wbit;
            assign wd_all[36*gp +: 36]   = wval;
            assign wbase_all[10*gp +: 10] = wb;
            assign wnl_all[2*gp +: 2]    = nlm1;
            assign wact_all[gp]          = wact;
            assign q_all[36*gp +: 36]    = q_q;
        end
    endgenerate

    // Array update; the mask path feeds no cleared register
    always @(posedge sys_clk_i) begin
        for (m_p = 0; m_p < 2; m_p = m_p + 1) begin
            for (m_k = 0; m_k < 4; m_k = m_k + 1) begin
                for (m_j = 0; m_j < 9; m_j = m_j + 1) begin
                    if (we_all[36*m_p + 9*m_k + m_j]) begin
                        mem[{wbase_all[10*m_p+2 +: 8],
                             wbase_all[10*m_p +: 2] | m_k[1:0]}][m_j]
                            <= wd_all[36*m_p + 9*m_k + m_j];
                    end
                end
            end
        end
    end

    // Configuration error flag
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_q <= `EBRC_ERR_RST;
        end else begin
            err_q <= !cfg_ok;
        end
    end

    // Outputs straight from flops
    assign a_rdata_o = q_all[35:0];
    assign b_rdata_o = q_all[71:36];
    assign cfg_err_o = err_q;

endmodule // ebrc_top

// ---- verif/ebrc_top_monitor.sv ----
// Purpose: concurrent checks on the block RAM core ports
// Assumes: one clock, async active-low reset
// Notes:   only the top module's ports are watched
module ebrc_top_monitor (
    // Clock and reset
    input wire        sys_clk_i,
    input wire        arst_n_i,
    // Configuration
    input wire [1:0]  mode_i,
    input wire        mix_old_i,
    input wire [3:0]  a_width_i,
    input wire [3:0]  b_width_i,
    input wire        a_out_reg_i,
    input wire        b_out_reg_i,
    // Port controls
    input wire        a_clk_en_i,
    input wire        b_clk_en_i,
    input wire        a_wr_en_i,
    input wire        b_wr_en_i,
    input wire        a_rd_en_i,
    input wire        b_rd_en_i,
    input wire        a_clr_i,
    input wire        b_clr_i,
    input wire        a_addr_hold_i,
    input wire        b_addr_hold_i,
    input wire [3:0]  a_lane_mask_i,
    input wire [12:0] a_addr_i,
    input wire [12:0] b_addr_i,
    // Observed outputs
    input wire [35:0] a_rdata_o,
    input wire [35:0] b_rdata_o,
    input wire        cfg_err_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Frozen ports keep their read data
    AST_A_FREEZE: assert property (
        !a_clk_en_i && !a_clr_i |=> $stable(a_rdata_o) || a_clr_i)
        else $error("port a output moved while clock enable low");
    AST_B_FREEZE: assert property (
        !b_clk_en_i && !b_clr_i |=> $stable(b_rdata_o) || b_clr_i)
        else $error("port b output moved while clock enable low");
    // No read enable with unregistered outputs: data holds
    AST_A_HOLD: assert property (
        a_clk_en_i && !a_rd_en_i && !a_out_reg_i && !a_clr_i |=> $stable(a_rdata_o) || a_clr_i)
        else $error("port a output moved without a read");
    AST_B_HOLD: assert property (
        b_clk_en_i && !b_rd_en_i && !b_out_reg_i && !b_clr_i |=> $stable(b_rdata_o) || b_clr_i)
        else $error("port b output moved without a read");
    // Clear forces the outputs low at once
    AST_A_CLR: assert property (a_clr_i |-> a_rdata_o == 36'h0)
        else $error("port a output not cleared");
    AST_B_CLR: assert property (b_clr_i |-> b_rdata_o == 36'h0)
        else $error("port b output not cleared");
    // Illegal shapes raise the error flag one edge later
    AST_WIDE_MIX: assert property (mode_i == 2'h2 && a_width_i != b_width_i &&
        (a_width_i == 4'h7 || a_width_i == 4'h8) |=> cfg_err_o) else $error("wide mix accepted");
    AST_PACK_WIDE: assert property (
        mode_i == 2'h3 && (a_width_i > 4'h6 || b_width_i > 4'h6) |=> cfg_err_o)
        else $error("wide packed port accepted");
    // Cross-port read of a written address returns all ones
    AST_XRDW: assert property (
        mode_i == 2'h2 && !mix_old_i && a_clk_en_i && b_clk_en_i && !b_clr_i &&
        a_wr_en_i && b_rd_en_i && !b_wr_en_i && !a_addr_hold_i && !b_addr_hold_i &&
        a_addr_i == b_addr_i && a_width_i == 4'h5 && b_width_i == 4'h5 && !b_out_reg_i &&
        a_lane_mask_i == 4'hF |=> b_rdata_o == 36'h0_0000_FFFF)
        else $error("cross-port read not all ones");
    // Main scenarios
    COV_CLR: cover property (a_clr_i);
    COV_ERR: cover property (cfg_err_o);
    COV_XRDW: cover property (mode_i == 2'h2 && a_wr_en_i && b_rd_en_i && a_addr_i == b_addr_i);
endmodule // ebrc_top_monitor

bind ebrc_top ebrc_top_monitor u_ebrc_top_monitor (.*);

// ---- verif/ebrc_user_port.sv ----
// Purpose: fabric logic driving one memory port
// Assumes: requests change on the falling edge only
// Notes:   released address and data lines show the inverse of their last value
module ebrc_user_port (
    // Clock
    input  wire         clk_i,
    // Port controls
    output logic        clk_en_o,
    output logic        wr_en_o,
    output logic        rd_en_o,
    output logic        hold_o,
    output logic        clr_o,
    output logic [3:0]  mask_o,
    output logic [12:0] addr_o,
    output logic [35:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle levels at time zero
    initial begin
        clk_en_o = 1'b1;
        wr_en_o  = 1'b0;
        rd_en_o  = 1'b0;
        hold_o   = 1'b0;
        clr_o    = 1'b0;
        mask_o   = 4'hF;
        addr_o   = 13'h0000;
        wdata_o  = 36'h0_0000_0000;
    end
    // One request per falling edge, held until the next call
    task automatic go(input logic ce, we, re, hd, input logic [12:0] ad,
                      input logic [35:0] d, input logic [3:0] m);
        @(negedge clk_i);
        clk_en_o = ce;
        wr_en_o  = we;
        rd_en_o  = re;
        hold_o   = hd;
        addr_o   = ad;
        wdata_o  = d;
        mask_o   = m;
    endtask
    // Unused operations are dropped, released lines flip
    task automatic idle();
        go(1'b1, 1'b0, 1'b0, 1'b0, ~addr_o, ~wdata_o, 4'hF);
    endtask
    // Clear is only moved while no read is pending
    task automatic clr_set(input logic v);
        @(negedge clk_i);
        clr_o = v;
    endtask
endmodule // ebrc_user_port

// ---- verif/ebrc_top_tb_top.sv ----
// Purpose: directed bench for the block RAM core
// Assumes: inputs change on the falling edge
// Notes:   read data is checked after the edge that returns it
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module ebrc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, arst_n = 1'b0, mix_old = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [3:0] a_width = 4'h5, b_width = 4'h5;
    logic a_out_reg = 1'b0, b_out_reg = 1'b0, a_rdw_new = 1'b0, b_rdw_new = 1'b0;
    wire a_ce, a_we, a_re, a_hd, a_cl, b_ce, b_we, b_re, b_hd, b_cl, cfg_err;
    wire [3:0] a_m, b_m;
    wire [12:0] a_ad, b_ad;
    wire [35:0] a_wd, b_wd, a_rdata, b_rdata;
    int n_fail = 0;
    int n_compared = 0;
    int wid[9] = '{1, 2, 4, 8, 9, 16, 18, 32, 36};
    int top[9] = '{8191, 4095, 2047, 1023, 1023, 511, 511, 255, 255};
    // Clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // Fabric logic at both ports
    ebrc_user_port u_ebrc_user_port_a (.clk_i(sys_clk), .clk_en_o(a_ce), .wr_en_o(a_we),
        .rd_en_o(a_re), .hold_o(a_hd), .clr_o(a_cl), .mask_o(a_m), .addr_o(a_ad), .wdata_o(a_wd));
    ebrc_user_port u_ebrc_user_port_b (.clk_i(sys_clk), .clk_en_o(b_ce), .wr_en_o(b_we),
        .rd_en_o(b_re), .hold_o(b_hd), .clr_o(b_cl), .mask_o(b_m), .addr_o(b_ad), .wdata_o(b_wd));
    // Device under test
    ebrc_top u_ebrc_top (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .mode_i(mode),
        .mix_old_i(mix_old),
        .a_width_i(a_width), .a_out_reg_i(a_out_reg), .a_rdw_new_i(a_rdw_new), .a_clk_en_i(a_ce),
        .a_wr_en_i(a_we), .a_rd_en_i(a_re), .a_addr_hold_i(a_hd), .a_clr_i(a_cl),
        .a_lane_mask_i(a_m), .a_addr_i(a_ad), .a_wdata_i(a_wd), .a_rdata_o(a_rdata),
        .b_width_i(b_width), .b_out_reg_i(b_out_reg), .b_rdw_new_i(b_rdw_new), .b_clk_en_i(b_ce),
        .b_wr_en_i(b_we), .b_rd_en_i(b_re), .b_addr_hold_i(b_hd), .b_clr_i(b_cl),
        .b_lane_mask_i(b_m), .b_addr_i(b_ad), .b_wdata_i(b_wd), .b_rdata_o(b_rdata),
        .cfg_err_o(cfg_err));
    // Port access helpers
    task automatic op(input bit p, input logic we, re, hd, input logic [12:0] ad,
                      input logic [35:0] d, input logic [3:0] m);
        if (p) u_ebrc_user_port_b.go(1'b1, we, re, hd, ad, d, m);
        else u_ebrc_user_port_a.go(1'b1, we, re, hd, ad, d, m);
    endtask
    task automatic idle(input bit p);
        if (p) u_ebrc_user_port_b.idle();
        else u_ebrc_user_port_a.idle();
    endtask
    task automatic wr(input bit p, input logic [12:0] ad, input logic [35:0] d,
                      input logic [3:0] m);
        op(p, 1'b1, 1'b0, 1'b0, ad, d, m);
        idle(p);
    endtask
    task automatic rd(input bit p, input logic [12:0] ad, input logic [35:0] exp);
        op(p, 1'b0, 1'b1, 1'b0, ad, 36'h0, 4'hF);
        idle(p);
        if ((p ? b_out_reg : a_out_reg) === 1'b1) idle(p);
        `CHK("rdata", exp, (p ? b_rdata : a_rdata))
    endtask
    // Both ports in the same cycle, lanes unmasked
    task automatic pair(input logic wa, ra, input logic [12:0] aa, input logic [35:0] da,
                        input logic wb, rb, input logic [12:0] ab, input logic [35:0] db);
        fork
            op(1'b0, wa, ra, 1'b0, aa, da, 4'hF);
            op(1'b1, wb, rb, 1'b0, ab, db, 4'hF);
        join
        fork
            idle(1'b0);
            idle(1'b1);
        join
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #1_000_000;
        n_fail++;
        finish_test;
    end
    // Test sequence
    initial begin
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        for (int i = 0; i < 9; i++) begin
            a_width = i[3:0];
            wr(0, top[i][12:0], 36'hA_5A5A_5A5A & ((36'h1 << wid[i]) - 36'h1), 4'hF);
            rd(0, top[i][12:0],
               36'hA_5A5A_5A5A & ((36'h1 << wid[i]) - 36'h1));
        end
        $display("test shapes done");
        a_width = 4'h8;
        wr(0, 13'h3, 36'hF_FFFF_FFFF, 4'hF);
        wr(0, 13'h3, 36'h0, 4'h5);
        rd(0, 13'h3, 36'hF_F803_FE00);
        a_width = 4'h6;
        wr(0, 13'h9, 36'h3_FFFF, 4'h3);
        wr(0, 13'h9, 36'h0, 4'h2);
        rd(0, 13'h9, 36'h1FF);
        a_width = 4'h3;
        wr(0, 13'h7, 36'h5A, 4'h0);
        rd(0, 13'h7, 36'h5A);
        a_width = 4'h5;
        wr(0, 13'h5, 36'h1234, 4'h3);
        wr(0, 13'h5, 36'hABCD, 4'h1);
        rd(0, 13'h5, 36'h12CD);
        $display("test masks done");
        wr(0, 13'h5, 36'hFFFF, 4'hF);
        `CHK("rdata", 36'h12CD, a_rdata)
        u_ebrc_user_port_a.go(1'b0, 1'b1, 1'b1, 1'b0, 13'h5, 36'h0, 4'hF);
        idle(0);
        `CHK("rdata", 36'h12CD, a_rdata)
        rd(0, 13'h5, 36'hFFFF);
        wr(0, 13'h6, 36'h0, 4'hF);
        op(0, 1'b0, 1'b1, 1'b0, 13'h5, 36'h0, 4'hF);
        op(0, 1'b0, 1'b1, 1'b1, 13'h6, 36'h0, 4'hF);
        idle(0);
        `CHK("rdata", 36'hFFFF, a_rdata)
        a_out_reg = 1'b1;
        op(0, 1'b0, 1'b1, 1'b0, 13'h6, 36'h0, 4'hF);
        idle(0);
        `CHK("rdata", 36'hFFFF, a_rdata)
        idle(0);
        `CHK("rdata", 36'h0, a_rdata)
        rd(0, 13'h5, 36'hFFFF);
        u_ebrc_user_port_a.clr_set(1'b1);
        #1 `CHK("rdata", 36'h0, a_rdata)
        u_ebrc_user_port_a.clr_set(1'b0);
        a_out_reg = 1'b0;
        $display("test controls done");
        op(0, 1'b1, 1'b1, 1'b0, 13'h5, 36'h1111, 4'hF);
        idle(0);
        `CHK("rdata", 36'hFFFF, a_rdata)
        a_rdw_new = 1'b1;
        op(0, 1'b1, 1'b1, 1'b0, 13'h5, 36'h2222, 4'h1);
        idle(0);
        `CHK("rdata", 36'h1122, a_rdata)
        $display("test read during write done");
        mode = 2'h2;
        pair(1'b1, 1'b0, 13'd20, 36'hAAAA, 1'b1, 1'b0, 13'd21, 36'hBBBB);
        pair(1'b0, 1'b1, 13'd21, 36'h0, 1'b0, 1'b1, 13'd20, 36'h0);
        `CHK("rdata a", 36'hBBBB, a_rdata)
        `CHK("rdata b", 36'hAAAA, b_rdata)
        pair(1'b1, 1'b0, 13'd20, 36'h0, 1'b0, 1'b1, 13'd20, 36'h0);
        `CHK("rdata b", 36'hFFFF, b_rdata)
        `CHK("rdata a", 36'hBBBB, a_rdata)
        mix_old = 1'b1;
        pair(1'b1, 1'b0, 13'd20, 36'h7777, 1'b0, 1'b1, 13'd20, 36'h0);
        `CHK("rdata b", 36'h0, b_rdata)
        $display("test dual port done");
        a_width = 4'h7;
        repeat (2) @(negedge sys_clk);
        `CHK("cfg_err", 1'b1, cfg_err)
        mode = 2'h3;
        a_width = 4'h8;
        b_width = 4'h6;
        repeat (2) @(negedge sys_clk);
        `CHK("cfg_err", 1'b1, cfg_err)
        a_width = 4'h6;
        repeat (2) @(negedge sys_clk);
        `CHK("cfg_err", 1'b0, cfg_err)
        pair(1'b1, 1'b0, 13'h3, 36'h1_2345, 1'b1, 1'b0, 13'h3, 36'h0_ABCD);
        pair(1'b0, 1'b1, 13'h3, 36'h0, 1'b0, 1'b1, 13'h3, 36'h0);
        `CHK("rdata a", 36'h1_2345, a_rdata)
        `CHK("rdata b", 36'h0_ABCD, b_rdata)
        // Simple dual-port: A only writes, B only reads; then freeze and clear B
        mode = 2'h1;
        pair(1'b1, 1'b0, 13'h4, 36'h0_5555, 1'b1, 1'b0, 13'h4, 36'h0_6666);
        pair(1'b0, 1'b1, 13'h4, 36'h0, 1'b0, 1'b1, 13'h4, 36'h0);
        `CHK("rdata a", 36'h1_2345, a_rdata)
        `CHK("rdata b", 36'h0_5555, b_rdata)
        u_ebrc_user_port_b.go(1'b0, 1'b0, 1'b1, 1'b0, 13'h3, 36'h0, 4'hF);
        idle(1);
        `CHK("rdata b", 36'h0_5555, b_rdata)
        u_ebrc_user_port_b.clr_set(1'b1);
        #1 `CHK("rdata b", 36'h0, b_rdata)
        u_ebrc_user_port_b.clr_set(1'b0);
        $display("test config done");
        finish_test;
    end
endmodule // ebrc_top_tb_top
